// File: hw/rtsic_pkg.sv
// Notes on behaviour
// - checksum-clear mode zeroes IPv4 UDP checksum
// - clear mode: bad UDP checksum corrupts FCS
// - fixup mode keeps checksum, appends 2-byte compensation
// - fixup mode: bad checksum stays bad after modification
// - seconds insert on writes seconds plus nanoseconds
// - seconds control ignored when insertion off
// - seconds length code selects one to four bytes
// - length ignored unless insertion and seconds on
// - nanoseconds offset from end or start
// - seconds offset after nanoseconds or from start
// - low sixteen duration bits in read-write register
// - temporary rate starts on low rate write
// - duration kept across activations
// - duration counted in clock cycles
// - insertion on suppresses timestamp readout
// - layer 2 append mode when insertion on
// - high ten bits extend duration count
package rtsic_pkg;
  // register addresses
  localparam logic [4:0]  ADDR_RX_INSERT_CONFIG = 5'h1d;
  localparam logic [4:0]  ADDR_TEMP_RATE_DUR_LO = 5'h1e;
  // rx_insert_config fields
  localparam int          FIX_BIT               = 15;
  localparam int          SEC_EN_BIT            = 14;
  localparam int          SEC_LEN_LSB           = 12;
  localparam int          NS_OFF_LSB            = 6;
  localparam int          SEC_OFF_LSB           = 0;
  // reset values
  localparam logic [15:0] RX_INSERT_CONFIG_RST  = 16'h0000;
  localparam logic [15:0] TEMP_RATE_DUR_LO_RST  = 16'h0000;
  localparam logic [9:0]  TEMP_RATE_DUR_HI_RST  = 10'h000;
  // stream buffer depth
  localparam int          BUF_DEPTH             = 2;
endpackage : rtsic_pkg

// File: hw/rtsic_buf.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry byte buffer; stalls upstream when full
module rtsic_buf (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // fill side
  input  wire logic [9:0] i_data,
  input  wire logic       i_valid,
  output logic            o_ready,
  // drain side
  output logic [9:0]      o_data,
  output logic            o_valid,
  input  wire logic       i_ready
);
  typedef struct packed {
    logic [1:0][9:0] mem;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
  } rtsic_buf_st_t;

  rtsic_buf_st_t s_q;
  rtsic_buf_st_t s_d;
  logic          push;
  logic          pop;

  // handshakes from occupancy
  assign o_ready = (s_q.cnt != 2'(rtsic_pkg::BUF_DEPTH));
  assign o_valid = (s_q.cnt != 2'd0);
  assign o_data  = s_q.mem[s_q.rp];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_data;
      s_d.wp          = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rtsic_buf
`default_nettype wire

// File: hw/rtsic_rate.sv
`timescale 1ns/1ps
`default_nettype none
// temporary rate duration counter
module rtsic_rate (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // control
  input  wire logic [25:0] i_duration,
  input  wire logic        i_rate_low_word_wr,
  // status
  output logic             o_temp_rate_active
);
  typedef struct packed {
    logic        active;
    logic [25:0] cnt;
  } rtsic_rate_st_t;

  rtsic_rate_st_t s_q;
  rtsic_rate_st_t s_d;

  // load on rate write, count clock cycles, then fall back
  always_comb begin
    s_d = s_q;
    if (i_rate_low_word_wr) begin
      s_d.active = (i_duration != 26'd0);
      s_d.cnt    = i_duration;
    end else if (s_q.active) begin
      s_d.cnt = s_q.cnt - 26'd1;
      if (s_q.cnt == 26'd1) begin
        s_d.active = 1'b0;
      end
    end
  end

  assign o_temp_rate_active = s_q.active;

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rtsic_rate
`default_nettype wire

// File: hw/rtsic_top.sv
`timescale 1ns/1ps
`default_nettype none
// receive timestamp insertion: register pair plus byte stream editor
module rtsic_top (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  // neighbour control bits
  input  wire logic        i_rx_stamp_insert_en,
  input  wire logic        i_rx_stamp_append_l2,
  input  wire logic [9:0]  i_temp_rate_duration_high,
  input  wire logic        i_rate_low_word_wr,
  output logic             o_temp_rate_active,
  output logic             o_stamp_readout_en,
  // frame context from parser
  input  wire logic        i_is_ipv4_udp,
  input  wire logic        i_is_l2,
  input  wire logic        i_udp_csum_bad,
  input  wire logic [31:0] i_stamp_sec,
  input  wire logic [31:0] i_stamp_ns,
  input  wire logic [15:0] i_csum_comp,
  // incoming bytes
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_sof,
  input  wire logic        i_rx_eom,
  input  wire logic        i_rx_csum_hi,
  input  wire logic        i_rx_csum_lo,
  input  wire logic        i_rx_fcs,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  // outgoing bytes
  output logic [7:0]       o_tx_data,
  output logic             o_tx_sof,
  output logic             o_tx_last,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready
);
  typedef enum {
    RTSIC_PASS,
    RTSIC_APP
  } rtsic_mode_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] dur_lo;
    logic [15:0] rdata;
    logic [5:0]  pos;
    logic [5:0]  app_cnt;
    logic [5:0]  app_len;
    logic        in_frame;
    logic        appending;
    logic [7:0]  out_data;
    logic        out_sof;
    logic        out_last;
    logic        out_valid;
  } rtsic_st_t;

  rtsic_st_t   s_q;
  rtsic_st_t   s_d;
  rtsic_mode_t mode;
  logic        fixup;
  logic        sec_on;
  logic [2:0]  sec_bytes;
  logic [5:0]  ns_off;
  logic [5:0]  sec_off;
  logic [5:0]  ns_pos;
  logic [5:0]  sec_pos;
  logic [5:0]  rel;
  logic [7:0]  byte_val;
  logic        stage_rdy;
  logic        take;
  logic        buf_ready;
  logic [9:0]  buf_out;
  logic [5:0]  cur_pos;
  logic        comp_on;

  // decoded configuration
  assign fixup     = s_q.cfg[rtsic_pkg::FIX_BIT];
  // compensation word only for ipv4 udp frames in fixup mode
  assign comp_on   = i_rx_stamp_insert_en && i_is_ipv4_udp && fixup;
  assign sec_on    = i_rx_stamp_insert_en && s_q.cfg[rtsic_pkg::SEC_EN_BIT];
  assign sec_bytes = sec_on ?
                     (3'(s_q.cfg[rtsic_pkg::SEC_LEN_LSB +: 2]) + 3'd1) : 3'd0;
  assign ns_off    = s_q.cfg[rtsic_pkg::NS_OFF_LSB +: 6];
  assign sec_off   = s_q.cfg[rtsic_pkg::SEC_OFF_LSB +: 6];
  assign mode      = (i_rx_stamp_insert_en && i_is_l2 && i_rx_stamp_append_l2) ?
                     RTSIC_APP : RTSIC_PASS;
  assign o_stamp_readout_en = !i_rx_stamp_insert_en;

  // field positions: append counts from message end, otherwise from start
  assign ns_pos  = ns_off;
  assign sec_pos = (mode == RTSIC_APP) ? 6'(ns_off + 6'd4 + sec_off) : sec_off;

  // staging register may load when empty or when buffer accepts it
  assign stage_rdy  = !s_q.out_valid || buf_ready;
  assign take       = i_rx_valid && stage_rdy && !s_q.appending;
  assign o_rx_ready = stage_rdy && !s_q.appending;

  // position of the byte on the input; the start byte is always position zero
  assign cur_pos = i_rx_sof ? 6'd0 : s_q.pos;

  // byte selector for an in-stream position
  always_comb begin
    byte_val = i_rx_data;
    rel      = cur_pos;
    if (i_rx_stamp_insert_en && mode == RTSIC_PASS) begin
      if (cur_pos >= ns_pos && cur_pos < 6'(ns_pos + 6'd4)) begin
        rel      = 6'(cur_pos - ns_pos);
        byte_val = i_stamp_ns[8'(6'd3 - rel) * 8 +: 8];
      end else if (cur_pos >= sec_pos && cur_pos < 6'(sec_pos + 6'(sec_bytes))) begin
        rel      = 6'(cur_pos - sec_pos);
        byte_val = i_stamp_sec[8'(6'(sec_bytes) - 6'd1 - rel) * 8 +: 8];
      end
    end
    if (i_rx_stamp_insert_en && i_is_ipv4_udp && (i_rx_csum_hi || i_rx_csum_lo)) begin
      if (!fixup) begin
        byte_val = 8'h00;
      end
    end
    if (i_rx_stamp_insert_en && i_rx_fcs && !fixup && i_udp_csum_bad) begin
      byte_val = ~i_rx_data;
    end
  end

  // register access, stream editing and append sequencing
  always_comb begin
    s_d = s_q;
    if (i_reg_wr && i_reg_addr == rtsic_pkg::ADDR_RX_INSERT_CONFIG) begin
      s_d.cfg = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == rtsic_pkg::ADDR_TEMP_RATE_DUR_LO) begin
      s_d.dur_lo = i_reg_wdata;
    end
    case (i_reg_addr)
      rtsic_pkg::ADDR_RX_INSERT_CONFIG: s_d.rdata = s_q.cfg;
      rtsic_pkg::ADDR_TEMP_RATE_DUR_LO: s_d.rdata = s_q.dur_lo;
      default:                          s_d.rdata = 16'h0000;
    endcase
    if (s_q.out_valid && buf_ready) begin
      s_d.out_valid = 1'b0;
    end
    if (take) begin
      s_d.out_data  = byte_val;
      s_d.out_sof   = i_rx_sof;
      s_d.out_valid = 1'b1;
      s_d.out_last  = 1'b0;
      s_d.pos       = i_rx_sof ? 6'd1 : ((s_q.pos == 6'h3f) ? s_q.pos : 6'(s_q.pos + 6'd1));
      if (i_rx_sof) begin
        s_d.pos = 6'd1;
      end
      s_d.in_frame = 1'b1;
      if (i_rx_eom) begin
        s_d.app_len = 6'd0;
        if (mode == RTSIC_APP) begin
          s_d.app_len = 6'(ns_off + 6'd4 + sec_off + 6'(sec_bytes));
        end
        if (comp_on) begin
          s_d.app_len = 6'(s_d.app_len + 6'd2);
        end
        s_d.app_cnt   = 6'd0;
        s_d.appending = (s_d.app_len != 6'd0);
        s_d.out_last  = (s_d.app_len == 6'd0);
      end
    end else if (s_q.appending && stage_rdy) begin
      s_d.out_valid = 1'b1;
      s_d.out_sof   = 1'b0;
      s_d.out_data  = 8'h00;
      if (mode == RTSIC_APP && s_q.app_cnt >= ns_off && s_q.app_cnt < 6'(ns_off + 6'd4)) begin
        s_d.out_data = i_stamp_ns[8'(6'd3 - 6'(s_q.app_cnt - ns_off)) * 8 +: 8];
      end else if (mode == RTSIC_APP && s_q.app_cnt >= sec_pos &&
                   s_q.app_cnt < 6'(sec_pos + 6'(sec_bytes))) begin
        s_d.out_data = i_stamp_sec[8'(6'(sec_bytes) - 6'd1 - 6'(s_q.app_cnt - sec_pos)) * 8 +: 8];
      end else if (comp_on && s_q.app_cnt == 6'(s_q.app_len - 6'd2)) begin
        // compensation high byte; flipped so a bad sum stays bad
        s_d.out_data = (i_csum_comp[15:8]) ^ {8{i_udp_csum_bad}};
      end else if (comp_on && s_q.app_cnt == 6'(s_q.app_len - 6'd1)) begin
        s_d.out_data = i_csum_comp[7:0];
      end
      s_d.app_cnt = 6'(s_q.app_cnt + 6'd1);
      if (s_q.app_cnt == 6'(s_q.app_len - 6'd1)) begin
        s_d.appending = 1'b0;
        s_d.out_last  = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q     <= '0;
      s_q.cfg <= rtsic_pkg::RX_INSERT_CONFIG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata = s_q.rdata;

  // output buffer absorbs receiver stalls
  rtsic_buf u_buf (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_data    ({s_q.out_sof, s_q.out_last, s_q.out_data}),
    .i_valid   (s_q.out_valid),
    .o_ready   (buf_ready),
    .o_data    (buf_out),
    .o_valid   (o_tx_valid),
    .i_ready   (i_tx_ready)
  );
  assign o_tx_sof  = buf_out[9];
  assign o_tx_last = buf_out[8];
  assign o_tx_data = buf_out[7:0];

  // duration counter with high bits from companion register
  rtsic_rate u_rate (
    .i_sys_clk          (i_sys_clk),
    .i_sys_rst          (i_sys_rst),
    .i_duration         ({i_temp_rate_duration_high, s_q.dur_lo}),
    .i_rate_low_word_wr (i_rate_low_word_wr),
    .o_temp_rate_active (o_temp_rate_active)
  );
endmodule : rtsic_top
`default_nettype wire

// File: test/rtsic_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port checks: register pair, rate timer, readout gate, output hold
module rtsic_chk (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_rx_stamp_insert_en,
  input wire logic [9:0] i_temp_rate_duration_high,
  input wire logic i_rate_low_word_wr,
  input wire logic o_temp_rate_active,
  input wire logic o_stamp_readout_en,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic [15:0] cfg_q;
  logic [15:0] lo_q;
  logic [25:0] dur;
  assign dur = {i_temp_rate_duration_high, lo_q};
  // shadow copies of the two registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cfg_q <= '0;
      lo_q <= '0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 5'h1d) cfg_q <= i_reg_wdata;
      if (i_reg_addr == 5'h1e) lo_q <= i_reg_wdata;
    end
  end
  chk_readout_gate: assert property (o_stamp_readout_en == !i_rx_stamp_insert_en)
    else $error("readout enable not gated by insertion");
  chk_rate_starts: assert property (i_rate_low_word_wr && dur != 0 |=> o_temp_rate_active)
    else $error("temporary rate did not start");
  chk_rate_zero: assert property (i_rate_low_word_wr && dur == 0 |=> !o_temp_rate_active)
    else $error("zero duration started a rate");
  chk_rate_ends: assert property (i_rate_low_word_wr && dur == 26'd3
    ##1 (!i_rate_low_word_wr)[*3] |=> !o_temp_rate_active)
    else $error("rate held past duration");
  chk_cfg_read: assert property ($past(i_reg_addr) == 5'h1d && !$past(i_reg_wr)
    |-> o_reg_rdata == $past(cfg_q)) else $error("config readback wrong");
  chk_dur_read: assert property ($past(i_reg_addr) == 5'h1e && !$past(i_reg_wr)
    |-> o_reg_rdata == $past(lo_q)) else $error("duration readback wrong");
  chk_unmapped_zero: assert property (!($past(i_reg_addr) inside {5'h1d, 5'h1e})
    |-> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("output byte dropped under stall");
endmodule : rtsic_chk
bind rtsic_top rtsic_chk u_chk (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
  .o_reg_rdata, .i_rx_stamp_insert_en, .i_temp_rate_duration_high, .i_rate_low_word_wr,
  .o_temp_rate_active, .o_stamp_readout_en, .o_tx_data, .o_tx_valid, .i_tx_ready);
`default_nettype wire

// File: test/rtsic_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// receiving mac: collects bytes, stalls every other cycle when slow
module rtsic_mac_model (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic [7:0] i_data,
  input wire logic i_sof,
  input wire logic i_last,
  input wire logic i_valid,
  output logic o_ready
);
  logic [7:0] q[$];
  int sof_at;
  int last_at;
  initial o_ready = 1'b1;
  // take a byte only at an edge where valid and ready are both high
  always @(posedge i_sys_clk) begin
    if (i_valid && o_ready) begin
      if (i_sof) sof_at = q.size();
      if (i_last) last_at = q.size();
      q.push_back(i_data);
    end
    o_ready <= i_slow ? ~o_ready : 1'b1;
  end
endmodule : rtsic_mac_model
`default_nettype wire

// File: test/rtsic_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module rtsic_top_tb_top;
  logic clk, rst, wr, rwr, ins, app, l2, ip, bad, sof, eom, chi, clo, fcs, vld, slow;
  logic act, roe, rrdy, tsof, tlast, tvld, trdy;
  logic [4:0] addr;
  logic [15:0] wd, rd;
  logic [9:0] hi;
  logic [7:0] dat, td;
  logic [7:0] e[$];
  logic [31:0] sn = 32'h1234_5678;
  logic [31:0] ss = 32'h9abc_def0;
  logic [15:0] cp = 16'h4c3d;
  int n_fail, checks;
  rtsic_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .i_rx_stamp_insert_en(ins),
    .i_rx_stamp_append_l2(app), .i_temp_rate_duration_high(hi), .i_rate_low_word_wr(rwr),
    .o_temp_rate_active(act), .o_stamp_readout_en(roe), .i_is_ipv4_udp(ip), .i_is_l2(l2),
    .i_udp_csum_bad(bad), .i_stamp_sec(ss), .i_stamp_ns(sn), .i_csum_comp(cp),
    .i_rx_data(dat), .i_rx_sof(sof), .i_rx_eom(eom), .i_rx_csum_hi(chi), .i_rx_csum_lo(clo),
    .i_rx_fcs(fcs), .i_rx_valid(vld), .o_rx_ready(rrdy), .o_tx_data(td), .o_tx_sof(tsof),
    .o_tx_last(tlast), .o_tx_valid(tvld), .i_tx_ready(trdy));
  rtsic_mac_model u_mac (.i_sys_clk(clk), .i_slow(slow), .i_data(td), .i_sof(tsof),
    .i_last(tlast), .i_valid(tvld), .o_ready(trdy));
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [4:0] a, input logic [15:0] x);
    addr <= a;
    @(posedge clk);
    #1;
    `CK(rd, x)
    @(posedge clk);
  endtask : rreg
  // pulse the rate word write and count active cycles
  task automatic rate(input int n);
    int c;
    c = 0;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    #1;
    while (act && c < 70000) begin
      c++;
      @(posedge clk);
      #1;
    end
    if (c >= 70000) begin
      n_fail++;
      wrap_up();
    end
    `CK(c, n)
    `CK(act, 1'b0)
    @(posedge clk);
  endtask : rate
  // one 20-byte frame: eom at 15, checksum at 2..3, fcs at 16..19
  task automatic run(input logic i_, a_, l_, b_, input logic [15:0] cf);
    int ns, so, ln, w, lx;
    logic [7:0] b;
    wreg(5'h1d, cf);
    ins <= i_;
    app <= a_;
    l2 <= l_;
    ip <= !l_;
    bad <= b_;
    ns = int'(cf[11:6]);
    so = int'(cf[5:0]);
    ln = cf[14] ? int'(cf[13:12]) + 1 : 0;
    e.delete();
    u_mac.q.delete();
    for (int p = 0; p < 20; p++) begin
      b = 8'(p + 16);
      if (i_ && !(a_ && l_) && p >= ns && p < ns + 4) b = sn[8*(ns+3-p) +: 8];
      if (i_ && !(a_ && l_) && p >= so && p < so + ln) b = ss[8*(so+ln-1-p) +: 8];
      if (i_ && !cf[15] && !l_ && (p == 2 || p == 3)) b = 8'h00;
      if (i_ && !cf[15] && b_ && p > 15) b = ~b;
      e.push_back(b);
      if (p == 15 && i_ && a_ && l_) begin
        for (w = 0; w < ns; w++) e.push_back(8'h00);
        for (w = 3; w >= 0; w--) e.push_back(sn[8*w +: 8]);
        for (w = 0; w < so; w++) e.push_back(8'h00);
        for (w = ln - 1; w >= 0; w--) e.push_back(ss[8*w +: 8]);
      end
      if (p == 15 && i_ && cf[15] && !l_) begin
        e.push_back(cp[15:8] ^ {8{b_}});
        e.push_back(cp[7:0]);
      end
      if (p == 15) lx = e.size() - 1;
    end
    for (int p = 0; p < 20; p++) begin
      dat <= 8'(p + 16);
      sof <= p == 0;
      eom <= p == 15;
      chi <= !l_ && p == 2;
      clo <= !l_ && p == 3;
      fcs <= p > 15;
      vld <= 1'b1;
      w = 0;
      @(posedge clk);
      while (!rrdy && w < 100) begin
        w++;
        @(posedge clk);
      end
      if (w >= 100) begin
        n_fail++;
        wrap_up();
      end
    end
    vld <= 1'b0;
    w = 0;
    while (u_mac.q.size() < e.size() && w < 300) begin
      w++;
      @(posedge clk);
    end
    if (w >= 300) begin
      n_fail++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
    `CK(u_mac.q.size(), e.size())
    foreach (e[k]) `CK(u_mac.q[k], e[k])
    `CK(u_mac.sof_at, 0)
    `CK(u_mac.last_at, lx)
  endtask : run
  // main sequence
  initial begin
    {wr, rwr, ins, app, l2, ip, bad, sof, eom, chi, clo, fcs, vld, slow} = '0;
    {addr, wd, hi, dat} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(5'h1d, rtsic_pkg::RX_INSERT_CONFIG_RST);
    rreg(5'h1e, rtsic_pkg::TEMP_RATE_DUR_LO_RST);
    wreg(5'h1e, 16'hffff);
    rreg(5'h1e, 16'hffff);
    rreg(5'h1f, 16'h0000);
    wreg(5'h1e, 16'h0003);
    rate(3);
    rate(3);
    wreg(5'h1e, 16'h0000);
    rate(0);
    hi <= 10'h001;
    wreg(5'h1e, 16'h0002);
    rate(65538);
    run(1'b0, 1'b0, 1'b0, 1'b1, 16'h710a);
    `CK(roe, 1'b1)
    run(1'b1, 1'b0, 1'b0, 1'b0, 16'h010a);
    `CK(roe, 1'b0)
    for (int n = 0; n < 4; n++) run(1'b1, 1'b0, 1'b0, n == 3, 16'h410a | 16'(n << 12));
    slow <= 1'b1;
    run(1'b1, 1'b0, 1'b0, 1'b0, 16'h810a);
    run(1'b1, 1'b0, 1'b0, 1'b1, 16'h810a);
    run(1'b1, 1'b1, 1'b1, 1'b0, 16'h5042);
    wrap_up();
  end
endmodule : rtsic_top_tb_top
`default_nettype wire
